// ### rtl/pisr_pkg.sv
// constants and helpers shared by the identity and status register bank
package pisr_pkg;

    // ==========================================================
    // register locations
    localparam logic [7:0] ADDR_PART_IDENTITY = 8'h3e;
    localparam logic [7:0] ADDR_SILICON_REVISION = 8'h3f;
    localparam logic [7:0] ADDR_TOP_CONTROL_HIDDEN = 8'h40;
    localparam logic [7:0] ADDR_RAIL3_EFFECTIVE_VOLTAGE = 8'h41;

    // ==========================================================
    // field layout and reset values
    localparam int INHIBIT_BIT = 4;
    localparam logic INHIBIT_RESET = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [3:0] FULL_MASK_FIRST = 4'ha;
    localparam logic [3:0] FULL_MASK_BIAS = 4'h9;
    localparam logic [2:0] FULL_MASK_NONE = 3'h0;
    localparam logic [2:0] FULL_MASK_WRAP = 3'h7;

    // ==========================================================
    // rail 3 voltage code scale, millivolts
    localparam logic [6:0] VID_SAT_CODE = 7'h50;
    localparam logic [10:0] VID_BASE_MV = 11'h1f4;
    localparam logic [10:0] VID_STEP_MV = 11'h00a;
    localparam logic [10:0] VID_TOP_MV = 11'h514;

    // full-mask change count to upper revision nibble
    function automatic logic [3:0] full_mask_code(input logic [2:0] n);
        if (n == FULL_MASK_NONE || n == FULL_MASK_WRAP) begin
            return FULL_MASK_FIRST;
        end
        return 4'(FULL_MASK_BIAS + {1'b0, n});
    endfunction

    // effective code to output level, saturated at the top code
    function automatic logic [10:0] vid_to_mv(input logic [6:0] code);
        logic [6:0] sat;
        sat = (code > VID_SAT_CODE) ? VID_SAT_CODE : code;
        return 11'(VID_BASE_MV + VID_STEP_MV * {4'h0, sat});
    endfunction

endpackage

// ### rtl/pisr_rail3_if.sv
// carrier for the rail 3 effective voltage between selector and bank
`timescale 1ns/1ps
interface pisr_rail3_if;
    logic [6:0] code;
    logic [10:0] mv;
    modport src (output code, output mv);
    modport dst (input code, input mv);
endinterface

// ### rtl/pisr_rail3_sel.sv
// rail 3 effective voltage selection between base and scaled codes
`timescale 1ns/1ps
module pisr_rail3_sel (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // selections in force
    input wire logic dvs_active_i,
    input wire logic [6:0] rail3_base_voltage_select_i,
    input wire logic [6:0] rail3_scaled_voltage_select_i,
    // effective value
    pisr_rail3_if.src eff
);

    // ==========================================================
    // selection
    logic [6:0] code_d;

    always_comb begin
        code_d = dvs_active_i ? rail3_scaled_voltage_select_i : rail3_base_voltage_select_i;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            eff.code <= 7'h00;
            eff.mv <= pisr_pkg::VID_BASE_MV;
        end else if (ce_i) begin
            eff.code <= code_d;
            eff.mv <= pisr_pkg::vid_to_mv(code_d);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_rail3_follows: assert property (ce_i |=> eff.code == $past(code_d))
        else $error("rail3 effective code does not follow the selection in force");
    a_rail3_scale: assert property (ce_i |=> eff.mv == pisr_pkg::vid_to_mv(eff.code))
        else $error("rail3 level does not match its code");
    a_rail3_sat: assert property (
        eff.code >= pisr_pkg::VID_SAT_CODE |-> eff.mv == pisr_pkg::VID_TOP_MV)
        else $error("rail3 top codes do not saturate");
    c_dvs_switch: cover property (ce_i && $rose(dvs_active_i));
    c_rail3_top: cover property (eff.code > pisr_pkg::VID_SAT_CODE);

endmodule

// ### rtl/pisr_top.sv
// identity, revision, hidden top control and rail 3 status register bank
//
// Functional notes
// - read-only part code at 0x3e, writes ignored
// - upper revision nibble counts full-mask changes, wraps
// - lower revision nibble counts metal changes, wraps
// - top control at 0x40 only in hidden mode
// - inhibit bit 4 set skips low output check
// - 0x41 reports rail 3 selection in force
// - code 0 is 0.5V, 10mV steps, saturates 1.30V
`timescale 1ns/1ps
module pisr_top #(
    // arbitrary neutral identity value
    parameter logic [7:0] PART_CODE = 8'h5a
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register port from the serial bus engine
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // device mode
    input wire logic hidden_mode_i,
    // revision straps, static pins
    input wire logic [2:0] full_mask_changes_i,
    input wire logic [4:0] metal_changes_i,
    // rail 3 selections
    input wire logic dvs_active_i,
    input wire logic [6:0] rail3_base_voltage_select_i,
    input wire logic [6:0] rail3_scaled_voltage_select_i,
    // low output comparator pin
    input wire logic rail_low_i,
    // status
    output logic low_output_check_inhibit_o,
    output logic low_output_fault_o,
    output logic [6:0] rail3_effective_voltage_code_o,
    output logic [10:0] rail3_target_mv_o
);

    // ==========================================================
    // pin synchronisers
    // straps and comparator reach logic two enabled edges after they move
    logic [2:0] fm_s1_q;
    logic [2:0] fm_s2_q;
    logic [4:0] mt_s1_q;
    logic [4:0] mt_s2_q;
    logic low_s1_q;
    logic low_s2_q;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fm_s1_q <= 3'h0;
            fm_s2_q <= 3'h0;
            mt_s1_q <= 5'h00;
            mt_s2_q <= 5'h00;
            low_s1_q <= 1'b0;
            low_s2_q <= 1'b0;
        end else if (ce_i) begin
            fm_s1_q <= full_mask_changes_i;
            fm_s2_q <= fm_s1_q;
            mt_s1_q <= metal_changes_i;
            mt_s2_q <= mt_s1_q;
            low_s1_q <= rail_low_i;
            low_s2_q <= low_s1_q;
        end
    end

    // ==========================================================
    // rail 3 selector
    pisr_rail3_if rail3 ();

    pisr_rail3_sel u_rail3 (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .dvs_active_i(dvs_active_i),
        .rail3_base_voltage_select_i(rail3_base_voltage_select_i),
        .rail3_scaled_voltage_select_i(rail3_scaled_voltage_select_i),
        .eff(rail3)
    );

    assign rail3_effective_voltage_code_o = rail3.code;
    assign rail3_target_mv_o = rail3.mv;

    // ==========================================================
    // decode
    logic top_wr;
    logic [7:0] revision;
    logic [7:0] rdata_d;

    always_comb begin
        top_wr = ce_i && reg_wr_i && hidden_mode_i
            && reg_addr_i == pisr_pkg::ADDR_TOP_CONTROL_HIDDEN;
        // upper nibble wraps after the seventh change, lower after sixteen
        // metal bit 4 only marks the sixteenth change and drops out of the nibble
        revision = {pisr_pkg::full_mask_code(fm_s2_q), mt_s2_q[3:0]};
    end

    always_comb begin
        rdata_d = pisr_pkg::READ_ZERO;
        case (reg_addr_i)
            pisr_pkg::ADDR_PART_IDENTITY: begin
                rdata_d = PART_CODE;
            end
            pisr_pkg::ADDR_SILICON_REVISION: begin
                rdata_d = revision;
            end
            pisr_pkg::ADDR_TOP_CONTROL_HIDDEN: begin
                if (hidden_mode_i) begin
                    rdata_d[pisr_pkg::INHIBIT_BIT] = low_output_check_inhibit_o;
                end
            end
            pisr_pkg::ADDR_RAIL3_EFFECTIVE_VOLTAGE: begin
                rdata_d = {rail3.code, 1'b0};
            end
            default: begin
                rdata_d = pisr_pkg::READ_ZERO;
            end
        endcase
    end

    // ==========================================================
    // top control, hidden mode only
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_output_check_inhibit_o <= pisr_pkg::INHIBIT_RESET;
        end else if (top_wr) begin
            low_output_check_inhibit_o <= reg_wdata_i[pisr_pkg::INHIBIT_BIT];
        end
    end

    // ==========================================================
    // low output check
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            low_output_fault_o <= 1'b0;
        end else if (ce_i) begin
            low_output_fault_o <= low_s2_q && !low_output_check_inhibit_o;
        end
    end

    // ==========================================================
    // read answer, registered mux with no state change
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= pisr_pkg::READ_ZERO;
            reg_rvalid_o <= 1'b0;
        end else if (ce_i) begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_part_readback: assert property (
        ce_i && reg_rd_i && reg_addr_i == pisr_pkg::ADDR_PART_IDENTITY
        |=> reg_rvalid_o && reg_rdata_o == PART_CODE)
        else $error("part code readback wrong");
    a_ro_writes: assert property (
        ce_i && reg_wr_i && reg_addr_i != pisr_pkg::ADDR_TOP_CONTROL_HIDDEN
        |=> $stable(low_output_check_inhibit_o))
        else $error("write to a read-only location changed control state");
    a_rev_upper: assert property (
        ce_i && reg_rd_i && reg_addr_i == pisr_pkg::ADDR_SILICON_REVISION
        |=> reg_rdata_o[7:4] == pisr_pkg::full_mask_code($past(fm_s2_q)))
        else $error("full-mask nibble wrong");
    a_rev_lower: assert property (
        ce_i && reg_rd_i && reg_addr_i == pisr_pkg::ADDR_SILICON_REVISION
        |=> reg_rdata_o[3:0] == $past(mt_s2_q[3:0]))
        else $error("metal nibble wrong");
    a_metal_wrap: assert property (
        ce_i && reg_rd_i && reg_addr_i == pisr_pkg::ADDR_SILICON_REVISION && mt_s2_q[4]
        |=> reg_rdata_o[3:0] == 4'h0)
        else $error("metal nibble did not wrap after sixteen changes");
    a_top_locked: assert property (!hidden_mode_i |=> $stable(low_output_check_inhibit_o))
        else $error("top control changed outside hidden mode");
    a_top_write: assert property (
        top_wr |=> low_output_check_inhibit_o == $past(reg_wdata_i[pisr_pkg::INHIBIT_BIT]))
        else $error("hidden write not stored");
    a_top_hidden_read: assert property (
        ce_i && reg_rd_i && !hidden_mode_i && reg_addr_i == pisr_pkg::ADDR_TOP_CONTROL_HIDDEN
        |=> reg_rdata_o == pisr_pkg::READ_ZERO)
        else $error("top control readable outside hidden mode");
    a_check_skip: assert property (
        ce_i && low_output_check_inhibit_o |=> !low_output_fault_o)
        else $error("low output flagged while inhibited");
    a_check_active: assert property (
        ce_i && !low_output_check_inhibit_o && low_s2_q |=> low_output_fault_o)
        else $error("low output not flagged");
    a_freeze_state: assert property (
        !ce_i |=> $stable(low_output_check_inhibit_o) && $stable(low_output_fault_o)
        && $stable(reg_rdata_o) && $stable(reg_rvalid_o))
        else $error("state moved while the clock enable was low");
    a_rail3_read: assert property (
        ce_i && reg_rd_i && reg_addr_i == pisr_pkg::ADDR_RAIL3_EFFECTIVE_VOLTAGE
        |=> reg_rdata_o == {$past(rail3.code), 1'b0})
        else $error("rail3 readback wrong");
    a_mv_range: assert property (
        rail3_target_mv_o >= pisr_pkg::VID_BASE_MV && rail3_target_mv_o <= pisr_pkg::VID_TOP_MV)
        else $error("rail3 level outside its scale");
    a_read_quiet: assert property (
        ce_i && reg_rd_i && !reg_wr_i |=> $stable(low_output_check_inhibit_o))
        else $error("read changed control state");
    a_rdata_hold: assert property (
        ce_i && !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    a_rvalid_pulse: assert property (
        ce_i && !reg_rd_i |=> !reg_rvalid_o)
        else $error("read answer without a read");
    c_hidden_write: cover property (top_wr && reg_wdata_i[pisr_pkg::INHIBIT_BIT]);
    c_low_fault: cover property ($rose(low_output_fault_o));
    c_rev_read: cover property (reg_rvalid_o && reg_rdata_o[7:4] == pisr_pkg::FULL_MASK_FIRST);

endmodule

// ### verif/pisr_host.sv
// host model issuing single-byte register reads and writes
`timescale 1ns/1ps
module pisr_host (
    // clock
    input wire logic clk_i,
    // register port
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    output logic reg_rd_o,
    input wire logic [7:0] reg_rdata_i,
    input wire logic reg_rvalid_i
);
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
        reg_rd_o = 1'b0;
    end
    // released lines show the inverse of their last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        n = 0;
        #1;
        while (reg_rvalid_i !== 1'b1 && n < 4) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        ok = (reg_rvalid_i === 1'b1);
        d = reg_rdata_i;
    endtask
endmodule

// ### verif/pisr_top_bench.sv
// self-checking bench for the identity and status register bank
`timescale 1ns/1ps
module pisr_top_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hidden_mode_i = 1'b0;
    logic dvs_active_i = 1'b0;
    logic rail_low_i = 1'b0;
    logic ce_i = 1'b1;
    logic [2:0] fm = 3'h1;
    logic [4:0] mc = 5'h00;
    logic [6:0] base = 7'h00;
    logic [6:0] scal = 7'h00;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, rvalid, inh, fault;
    logic [6:0] code;
    logic [10:0] mv;
    int checks = 0;
    int bad_count = 0;
    always #20 clk_i = ~clk_i;
    pisr_host host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
        .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
    // part code value here is arbitrary
    pisr_top #(.PART_CODE(8'h3c)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .hidden_mode_i(hidden_mode_i),
        .full_mask_changes_i(fm), .metal_changes_i(mc), .dvs_active_i(dvs_active_i),
        .rail3_base_voltage_select_i(base), .rail3_scaled_voltage_select_i(scal),
        .rail_low_i(rail_low_i), .low_output_check_inhibit_o(inh),
        .low_output_fault_o(fault), .rail3_effective_voltage_code_o(code),
        .rail3_target_mv_o(mv));
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
        checks++;
        if (e !== g) begin
            $display("[ERR] %s expected %h seen %h", what, e, g);
            bad_count++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic ok;
        host.rd(a, d, ok);
        chk("rvalid", 11'h001, {10'h000, ok});
        if (ok !== 1'b1) begin
            wrap_up();
        end else begin
            chk("rdata", {3'h0, e}, {3'h0, d});
        end
    endtask
    task automatic t_ident();
        rdc(8'h3e, 8'h3c);
        host.wr(8'h3e, 8'ha5);
        rdc(8'h3e, 8'h3c);
        rdc(8'h3e, 8'h3c);
        rdc(8'h42, 8'h00);
        $display("test ident done");
    endtask
    task automatic t_rev();
        logic [4:0] ms [4] = '{5'h00, 5'h01, 5'h0f, 5'h10};
        logic [3:0] lo [4] = '{4'h0, 4'h1, 4'hf, 4'h0};
        logic [3:0] up [8] = '{4'ha, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'ha};
        for (int n = 0; n < 8; n++) begin
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_i);
                fm <= 3'(n);
                mc <= ms[k];
                tick(3);
                rdc(8'h3f, {up[n], lo[k]});
            end
        end
        $display("test rev done");
    endtask
    task automatic t_hidden();
        host.wr(8'h40, 8'h10);
        tick(1);
        chk("inhibit", 11'h000, {10'h000, inh});
        rdc(8'h40, 8'h00);
        @(posedge clk_i);
        hidden_mode_i <= 1'b1;
        rail_low_i <= 1'b1;
        tick(5);
        chk("fault", 11'h001, {10'h000, fault});
        host.wr(8'h40, 8'h10);
        tick(2);
        chk("fault", 11'h000, {10'h000, fault});
        rdc(8'h40, 8'h10);
        @(posedge clk_i);
        hidden_mode_i <= 1'b0;
        host.wr(8'h40, 8'h00);
        tick(2);
        chk("inhibit", 11'h001, {10'h000, inh});
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        rail_low_i <= 1'b0;
        tick(2);
        rst_n_i <= 1'b1;
        tick(3);
        chk("inhibit", 11'h000, {10'h000, inh});
        chk("fault", 11'h000, {10'h000, fault});
        chk("rdata", 11'h000, {3'h0, rdata});
        chk("rvalid", 11'h000, {10'h000, rvalid});
        $display("test hidden done");
    endtask
    task automatic t_freeze();
        @(posedge clk_i);
        ce_i <= 1'b0;
        base <= 7'h2a;
        rail_low_i <= 1'b1;
        tick(4);
        chk("code", 11'h000, {4'h0, code});
        chk("mv", 11'd500, mv);
        chk("fault", 11'h000, {10'h000, fault});
        @(posedge clk_i);
        ce_i <= 1'b1;
        tick(4);
        chk("code", 11'h02a, {4'h0, code});
        chk("mv", 11'd920, mv);
        chk("fault", 11'h001, {10'h000, fault});
        rdc(8'h41, 8'h54);
        @(posedge clk_i);
        rail_low_i <= 1'b0;
        $display("test freeze done");
    endtask
    task automatic t_rail();
        logic [6:0] cs [6] = '{7'h00, 7'h01, 7'h4f, 7'h50, 7'h51, 7'h7f};
        for (int k = 0; k < 6; k++) begin
            for (int s = 0; s < 2; s++) begin
                @(posedge clk_i);
                base <= s ? ~cs[k] : cs[k];
                scal <= s ? cs[k] : ~cs[k];
                dvs_active_i <= 1'(s);
                tick(2);
                chk("code", {4'h0, cs[k]}, {4'h0, code});
                chk("mv", (cs[k] > 7'h50) ? 11'd1300 : 11'(500 + 10 * cs[k]), mv);
                rdc(8'h41, {cs[k], 1'b0});
            end
        end
        $display("test rail done");
    endtask
    initial begin
        tick(5);
        chk("mv", 11'd500, mv);
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        tick(3);
        t_ident();
        t_rev();
        t_hidden();
        t_freeze();
        t_rail();
        wrap_up();
    end
endmodule
